// File: design/pcr_top.sv
// pll control: pump gating, lock/ref mux, divider encodings, delay resolution, reference, registers
//
// Contract
// - The pump is on when forced on (default), otherwise only while the hold input matches the level chosen by the polarity bit.
// - The pump turns off at once without a clock when gating fails and back on at the second sync edge after gating returns.
// - lock_ref_out gives low, lock, reserved, sync xor inversion, or the divided reference according to the two-bit select and phase reference bit.
// - The output clock divider code selects divide by 1, 2, 4 or 8, divide by 1 after reset.
// - The pump current code selects 1 to 64 microamps in powers of two, code 111 being reserved.
// - The VCO divider code selects 2 (default), 4, 8 or 16.
// - The delay resolution code selects 16, 32 or 64 elements with maxima 0F, 1F, 3F, code 10 being reserved.
// - The delay resolution is a shadow that reaches the working register only on writing low nibble A to register 8.
// - The reference is high for exactly one oscillator period.
// - The reference is low for count plus one oscillator periods, count zero being reserved.
// - The phase detector takes the divided reference instead of sync when the phase reference bit is set.
// - Filter bit 0 selects the external loop filter and 1 the internal one.
// - A read-only status bit shows 1 while locked and 0 while unlocked.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`default_nettype none
module pcr_top
	import pcr_pkg::*;
#(
	parameter int OSC_COUNT_W = 7
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output var  logic [7:0]  reg_rdata,
	input  wire logic        hold_input,
	input  wire logic        sync_in,
	input  wire logic        pll_locked,
	output var  logic        pump_enable,
	output var  logic [6:0]  pump_current_ua,
	output var  logic [4:0]  vco_div_ratio,
	output var  logic [3:0]  clk_div_ratio,
	output var  logic [6:0]  phase_delay_elements,
	output var  logic [5:0]  phase_delay_line,
	output var  logic        phase_delay_bypass,
	output var  logic        filter_internal,
	output var  logic        detector_input,
	output var  logic        lock_ref_out,
	output var  logic        irq
);
	logic [7:0]         ctrl_reg;
	logic [7:0]         pump_reg;
	logic [2:0]         current_work_reg;
	logic [7:0]         delay_reg;
	logic [1:0]         res_shadow_reg;
	logic [1:0]         res_work_reg;
	logic [7:0]         clkdiv_reg;
	logic [7:0]         osc_reg;
	logic [PCR_I_COUNT-1:0] int_status_reg;
	logic [PCR_I_COUNT-1:0] int_mask_reg;
	logic [PCR_I_COUNT-1:0] int_event;
	logic [7:0]         rdata_next;
	logic               locked_reg;
	logic               sync_prev_reg;
	logic               sync_rise;
	logic               pump_gate_ok;
	logic               pump_clr_n;
	logic               pump_prev_reg;
	logic               delay_load;
	logic               ref_signal;
	logic               lock_ref_next;
	logic [1:0]         lockref_sel;
	logic [5:0]         delay_max;
	logic [5:0]         phase_delay_offset;
	pcr_pump_state_type pump_state_reg;

	logic               wr_ctrl;
	logic               wr_pump;
	logic               wr_delay;
	logic               wr_res;
	logic               wr_clkdiv;
	logic               wr_osc;
	logic               wr_softrst;
	logic               wr_int_status;
	logic               wr_int_mask;

	// write enables, decoded once from the bus so every reader sees the same strobe
	assign wr_ctrl       = reg_write && (reg_addr == PCR_REG_CTRL);
	assign wr_pump       = reg_write && (reg_addr == PCR_REG_PUMP);
	assign wr_delay      = reg_write && (reg_addr == PCR_REG_DELAY);
	assign wr_res        = reg_write && (reg_addr == PCR_REG_RES);
	assign wr_clkdiv     = reg_write && (reg_addr == PCR_REG_CLKDIV);
	assign wr_osc        = reg_write && (reg_addr == PCR_REG_OSC);
	assign wr_softrst    = reg_write && (reg_addr == PCR_REG_SOFTRST);
	assign wr_int_status = reg_write && (reg_addr == PCR_REG_INT_STATUS);
	assign wr_int_mask   = reg_write && (reg_addr == PCR_REG_INT_MASK);

	// ---------------------------------------------------------------- registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg   <= PCR_RST_CTRL;
			pump_reg   <= PCR_RST_PUMP;
			delay_reg  <= PCR_RST_DELAY;
			clkdiv_reg <= PCR_RST_CLKDIV;
			osc_reg    <= PCR_RST_OSC;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= reg_wdata;
			if (wr_pump)
				pump_reg <= reg_wdata;
			if (wr_delay)
				delay_reg <= reg_wdata;
			if (wr_clkdiv)
				clkdiv_reg <= reg_wdata;
			if (wr_osc)
				osc_reg <= reg_wdata;
		end
	end

	// pump current working copy only follows valid codes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			current_work_reg <= PCR_RST_PUMP[PCR_F_CURRENT_LO +: 3];
		end else if (wr_pump &&
		             reg_wdata[PCR_F_CURRENT_LO +: 3] != PCR_CURRENT_RSVD) begin
			current_work_reg <= reg_wdata[PCR_F_CURRENT_LO +: 3];
		end
	end

	// delay resolution: shadow written by software, working copy loaded by soft reset
	assign delay_load = wr_softrst && (reg_wdata[3:0] == PCR_SOFTRST_KEY);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			res_shadow_reg <= PCR_RST_RES[PCR_F_RES_LO +: 2];
			res_work_reg   <= PCR_RST_RES[PCR_F_RES_LO +: 2];
		end else begin
			if (wr_res)
				res_shadow_reg <= reg_wdata[PCR_F_RES_LO +: 2];
			if (delay_load && res_shadow_reg != PCR_RES_RSVD)
				res_work_reg <= res_shadow_reg;
		end
	end

	// ---------------------------------------------------------------- pump gating
	always_comb begin
		if (ctrl_reg[PCR_F_FORCE_ON])
			pump_gate_ok = 1'b1;
		else if (ctrl_reg[PCR_F_PUMP_POL])
			pump_gate_ok = !hold_input;
		else
			pump_gate_ok = hold_input;
	end

	// gating failure clears the pump without waiting for a clock edge
	assign pump_clr_n = reset_n & pump_gate_ok;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync_prev_reg <= 1'b0;
		end else begin
			sync_prev_reg <= sync_in;
		end
	end

	assign sync_rise = sync_in && !sync_prev_reg;

	always_ff @(posedge clock or negedge pump_clr_n) begin
		if (!pump_clr_n) begin
			pump_state_reg <= PCR_PUMP_OFF;
			pump_enable    <= 1'b0;
		end else begin
			case (pump_state_reg)
				PCR_PUMP_OFF: begin
					pump_enable <= 1'b0;
					if (ctrl_reg[PCR_F_FORCE_ON]) begin
						pump_state_reg <= PCR_PUMP_ON;
						pump_enable    <= 1'b1;
					end else if (sync_rise) begin
						pump_state_reg <= PCR_PUMP_WAIT;
					end
				end
				PCR_PUMP_WAIT: begin
					pump_enable <= 1'b0;
					if (ctrl_reg[PCR_F_FORCE_ON] || sync_rise) begin
						pump_state_reg <= PCR_PUMP_ON;
						pump_enable    <= 1'b1;
					end
				end
				PCR_PUMP_ON: begin
					pump_enable <= 1'b1;
				end
				default: begin
					pump_state_reg <= PCR_PUMP_OFF;
					pump_enable    <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------- reference
	pcr_ref_gen #(
		.COUNT_W   (OSC_COUNT_W)
	) u_ref_gen (
		.clock     (clock),
		.reset_n   (reset_n),
		.low_count (osc_reg[PCR_F_OSCDIV_LO +: OSC_COUNT_W]),
		.ref_out   (ref_signal)
	);

	// ---------------------------------------------------------------- lock and mux
	assign lockref_sel = ctrl_reg[PCR_F_LOCKREF_LO +: 2];

	always_comb begin
		case (lockref_sel)
			PCR_LR_LOW:      lock_ref_next = 1'b0;
			PCR_LR_LOCK:     lock_ref_next = pll_locked;
			PCR_LR_SYNC_REF: lock_ref_next = osc_reg[PCR_F_PHASE_REF] ? ref_signal
			                                 : (sync_in ^ ctrl_reg[PCR_F_SYNC_INV]);
			default:         lock_ref_next = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_ref_out   <= 1'b0;
			detector_input <= 1'b0;
		end else begin
			lock_ref_out   <= lock_ref_next;
			detector_input <= osc_reg[PCR_F_PHASE_REF] ? ref_signal : sync_in;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			locked_reg <= 1'b0;
		end else begin
			locked_reg <= pll_locked;
		end
	end

	// ---------------------------------------------------------------- analog settings
	always_comb begin
		case (res_work_reg)
			PCR_RES_32: delay_max = PCR_MAX_32;
			PCR_RES_64: delay_max = PCR_MAX_64;
			default:    delay_max = PCR_MAX_16;
		endcase
	end

	assign phase_delay_offset = delay_reg[PCR_F_OFFSET_LO +: 6];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pump_current_ua      <= PCR_CURRENT_UNIT;
			vco_div_ratio        <= PCR_VCO_UNIT;
			clk_div_ratio        <= PCR_CLKDIV_UNIT;
			phase_delay_elements <= PCR_ELEM_16;
			phase_delay_line     <= '0;
			phase_delay_bypass   <= 1'b1;
			filter_internal      <= 1'b0;
		end else begin
			pump_current_ua <= PCR_CURRENT_UNIT << current_work_reg;
			vco_div_ratio   <= PCR_VCO_UNIT << pump_reg[PCR_F_VCO_LO +: 2];
			clk_div_ratio   <= PCR_CLKDIV_UNIT << clkdiv_reg[PCR_F_CLKDIV_LO +: 2];
			case (res_work_reg)
				PCR_RES_32: phase_delay_elements <= PCR_ELEM_32;
				PCR_RES_64: phase_delay_elements <= PCR_ELEM_64;
				default:    phase_delay_elements <= PCR_ELEM_16;
			endcase
			// selection is clamped to the last element of the chosen line
			phase_delay_line   <= (phase_delay_offset > delay_max) ? delay_max
			                                                       : phase_delay_offset;
			phase_delay_bypass <= (phase_delay_offset == '0);
			filter_internal    <= delay_reg[PCR_F_FILTER];
		end
	end

	// ---------------------------------------------------------------- interrupts
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pump_prev_reg <= 1'b0;
		end else begin
			pump_prev_reg <= pump_enable;
		end
	end

	assign int_event[PCR_I_LOCK_CHANGE] = locked_reg != pll_locked;
	assign int_event[PCR_I_PUMP_OFF]    = pump_prev_reg && !pump_enable;
	assign int_event[PCR_I_DELAY_LOAD]  = delay_load;

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int_status_reg <= '0;
		end else if (wr_int_status) begin
			int_status_reg <= (int_status_reg & ~reg_wdata[PCR_I_COUNT-1:0]) | int_event;
		end else begin
			int_status_reg <= int_status_reg | int_event;
		end
	end

	// the mask only gates the irq line; status bits still collect events
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int_mask_reg <= PCR_RST_MASK[PCR_I_COUNT-1:0];
		end else if (wr_int_mask) begin
			int_mask_reg <= reg_wdata[PCR_I_COUNT-1:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_reg & int_mask_reg);
		end
	end

	// ---------------------------------------------------------------- read port
	always_comb begin
		rdata_next = 8'h00;
		case (reg_addr)
			PCR_REG_CTRL:       rdata_next = ctrl_reg;
			PCR_REG_PUMP:       rdata_next = pump_reg;
			PCR_REG_DELAY:      rdata_next = delay_reg;
			PCR_REG_RES:        rdata_next = {6'h00, res_shadow_reg};
			PCR_REG_CLKDIV:     rdata_next = clkdiv_reg;
			PCR_REG_OSC:        rdata_next = osc_reg;
			PCR_REG_STATUS:     rdata_next[PCR_F_LOCK] = locked_reg;
			PCR_REG_INT_STATUS: rdata_next[PCR_I_COUNT-1:0] = int_status_reg;
			PCR_REG_INT_MASK:   rdata_next[PCR_I_COUNT-1:0] = int_mask_reg;
			default:            rdata_next = 8'h00;
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : pcr_top
`default_nettype wire

// File: design/pcr_pkg.sv
// package: register map, field layout, reset values and encodings of the pll control block
`default_nettype none
package pcr_pkg;
	localparam int          PCR_CLOCK_HZ        = 25000000;
	localparam int          PCR_ADDR_W          = 8;
	localparam int          PCR_DATA_W          = 8;

	// register indices
	localparam logic [7:0]  PCR_REG_CTRL        = 8'h00;
	localparam logic [7:0]  PCR_REG_PUMP        = 8'h01;
	localparam logic [7:0]  PCR_REG_DELAY       = 8'h04;
	localparam logic [7:0]  PCR_REG_RES         = 8'h05;
	localparam logic [7:0]  PCR_REG_CLKDIV      = 8'h06;
	localparam logic [7:0]  PCR_REG_OSC         = 8'h07;
	localparam logic [7:0]  PCR_REG_SOFTRST     = 8'h08;
	localparam logic [7:0]  PCR_REG_STATUS      = 8'h12;
	localparam logic [7:0]  PCR_REG_INT_STATUS  = 8'h13;
	localparam logic [7:0]  PCR_REG_INT_MASK    = 8'h14;

	// field positions
	localparam int          PCR_F_FORCE_ON      = 0;
	localparam int          PCR_F_PUMP_POL      = 1;
	localparam int          PCR_F_SYNC_INV      = 2;
	localparam int          PCR_F_LOCKREF_LO    = 6;
	localparam int          PCR_F_CURRENT_LO    = 0;
	localparam int          PCR_F_VCO_LO        = 4;
	localparam int          PCR_F_OFFSET_LO     = 0;
	localparam int          PCR_F_FILTER        = 7;
	localparam int          PCR_F_RES_LO        = 0;
	localparam int          PCR_F_CLKDIV_LO     = 6;
	localparam int          PCR_F_OSCDIV_LO     = 0;
	localparam int          PCR_F_PHASE_REF     = 7;
	localparam int          PCR_F_LOCK          = 1;

	// reset values
	localparam logic [7:0]  PCR_RST_CTRL        = 8'h01;
	localparam logic [7:0]  PCR_RST_PUMP        = 8'h00;
	localparam logic [7:0]  PCR_RST_DELAY       = 8'h00;
	localparam logic [7:0]  PCR_RST_RES         = 8'h00;
	localparam logic [7:0]  PCR_RST_CLKDIV      = 8'h00;
	localparam logic [7:0]  PCR_RST_OSC         = 8'h01;
	localparam logic [7:0]  PCR_RST_MASK        = 8'h00;

	// codes
	localparam logic [3:0]  PCR_SOFTRST_KEY     = 4'ha;
	localparam logic [1:0]  PCR_LR_LOW          = 2'h0;
	localparam logic [1:0]  PCR_LR_LOCK         = 2'h1;
	localparam logic [1:0]  PCR_LR_RSVD         = 2'h2;
	localparam logic [1:0]  PCR_LR_SYNC_REF     = 2'h3;
	localparam logic [2:0]  PCR_CURRENT_RSVD    = 3'h7;
	localparam logic [1:0]  PCR_RES_16          = 2'h0;
	localparam logic [1:0]  PCR_RES_32          = 2'h1;
	localparam logic [1:0]  PCR_RES_RSVD        = 2'h2;
	localparam logic [1:0]  PCR_RES_64          = 2'h3;
	localparam logic [6:0]  PCR_ELEM_16         = 7'h10;
	localparam logic [6:0]  PCR_ELEM_32         = 7'h20;
	localparam logic [6:0]  PCR_ELEM_64         = 7'h40;
	localparam logic [5:0]  PCR_MAX_16          = 6'h0f;
	localparam logic [5:0]  PCR_MAX_32          = 6'h1f;
	localparam logic [5:0]  PCR_MAX_64          = 6'h3f;
	localparam logic [6:0]  PCR_OSC_MIN         = 7'h01;
	localparam logic [6:0]  PCR_CURRENT_UNIT    = 7'h01;
	localparam logic [4:0]  PCR_VCO_UNIT        = 5'h02;
	localparam logic [3:0]  PCR_CLKDIV_UNIT     = 4'h1;

	// interrupt status bits
	localparam int          PCR_I_LOCK_CHANGE   = 0;
	localparam int          PCR_I_PUMP_OFF      = 1;
	localparam int          PCR_I_DELAY_LOAD    = 2;
	localparam int          PCR_I_COUNT         = 3;

	typedef enum logic [2:0] {
		PCR_PUMP_OFF  = 3'b001,
		PCR_PUMP_WAIT = 3'b010,
		PCR_PUMP_ON   = 3'b100
	} pcr_pump_state_type;
endpackage : pcr_pkg
`default_nettype wire

// File: design/pcr_ref_gen.sv
// reference generator: one oscillator period high, (count + 1) periods low
`default_nettype none
module pcr_ref_gen
	import pcr_pkg::*;
#(
	parameter int COUNT_W = 7
) (
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic [COUNT_W-1:0] low_count,
	output var  logic               ref_out
);
	logic [COUNT_W:0] low_left_reg;
	logic [COUNT_W:0] low_load;

	// a count of zero is reserved; it is run as the shortest legal count
	assign low_load = (low_count == '0) ? {1'b0, COUNT_W'(PCR_OSC_MIN)} + 1'b1
	                                    : {1'b0, low_count} + 1'b1;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ref_out      <= 1'b0;
			low_left_reg <= '0;
		end else if (ref_out) begin
			ref_out      <= 1'b0;
			low_left_reg <= low_load - 1'b1;
		end else if (low_left_reg == '0) begin
			ref_out      <= 1'b1;
			low_left_reg <= '0;
		end else begin
			low_left_reg <= low_left_reg - 1'b1;
		end
	end
endmodule : pcr_ref_gen
`default_nettype wire

// File: tb/pcr_sync_src.sv
// partner model: horizontal sync source, idle low while not running
`default_nettype none
module pcr_sync_src #(
	parameter int PERIOD = 12,
	parameter int HIGH   = 3
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic run,
	output var  logic sync_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int phase;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n || !run) begin
			phase <= 0;
			sync_in <= 1'b0;
		end else begin
			phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
			sync_in <= (phase < HIGH);
		end
	end
endmodule : pcr_sync_src
`default_nettype wire

// File: tb/pcr_properties.sv
// checker: port-level properties of the pll control block
`default_nettype none
module pcr_properties
	import pcr_pkg::*;
#(
	parameter int OSC_COUNT_W = 7
) (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       hold_input,
	input wire logic       sync_in,
	input wire logic       pll_locked,
	input wire logic       pump_enable,
	input wire logic [6:0] pump_current_ua,
	input wire logic [4:0] vco_div_ratio,
	input wire logic [3:0] clk_div_ratio,
	input wire logic [6:0] phase_delay_elements,
	input wire logic [5:0] phase_delay_line,
	input wire logic       phase_delay_bypass,
	input wire logic       filter_internal,
	input wire logic       detector_input,
	input wire logic       lock_ref_out,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] r_q [0:7];
	logic [7:0] lo_cnt;
	logic [7:0] settle;
	logic       lr_exp;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// mirror of the low control registers as written on the bus
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		end else if (reg_write && reg_addr[7:3] == 5'h00) begin
			r_q[reg_addr[2:0]] <= reg_wdata;
		end
	end

	// low run length of the reference, and time since its count was written
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lo_cnt <= 8'h00;
			settle <= 8'h00;
		end else begin
			lo_cnt <= detector_input ? 8'h00 : lo_cnt + 8'h01;
			settle <= (reg_write && reg_addr == 8'h07) ? 8'h00 :
				((settle == 8'hff) ? settle : settle + 8'h01);
		end
	end

	always_comb begin
		case (r_q[0][7:6])
			2'h1: lr_exp = pll_locked;
			2'h3: lr_exp = sync_in ^ r_q[0][2];
			default: lr_exp = 1'b0;
		endcase
	end

	a_pump_gate_off: assert property (
		!r_q[0][0] && hold_input == r_q[0][1] |-> !pump_enable)
		else $error("pump enabled while gating fails");
	a_pump_resume: assert property (
		$rose(pump_enable) && !r_q[0][0] |-> $past(sync_in) && !$past(sync_in, 2))
		else $error("pump resumed away from a sync rise");
	a_lockref_mux: assert property (
		!(r_q[0][7:6] == 2'h3 && r_q[7][7]) |=> lock_ref_out == $past(lr_exp))
		else $error("lock ref output wrong");
	a_lockref_ref: assert property (
		r_q[0][7:6] == 2'h3 && r_q[7][7] |=> lock_ref_out == detector_input)
		else $error("lock ref output not the reference");
	a_ref_high_one: assert property (
		$rose(detector_input) && r_q[7][7] && settle == 8'hff |=> !detector_input)
		else $error("reference high longer than one cycle");
	a_ref_low_len: assert property (
		$rose(detector_input) && r_q[7][7] && settle == 8'hff |->
		lo_cnt == 8'(r_q[7][6:0]) + ((r_q[7][6:0] == 7'h00) ? 8'h02 : 8'h01))
		else $error("reference low time wrong");
	a_detector_sync: assert property (
		!r_q[7][7] |=> detector_input == $past(sync_in))
		else $error("detector input not the sync");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_status_read: assert property (
		reg_read && reg_addr == 8'h12 |=> reg_rdata == {6'h00, $past(pll_locked, 2), 1'b0})
		else $error("lock status read wrong");
	a_field_outs: assert property (1'b1 |=>
		phase_delay_bypass == ($past(r_q[4][5:0]) == 6'h00) &&
		filter_internal == $past(r_q[4][7]) &&
		vco_div_ratio == (5'h02 << $past(r_q[1][5:4])) &&
		clk_div_ratio == (4'h1 << $past(r_q[6][7:6])))
		else $error("field output wrong");
	a_current_code: assert property (
		r_q[1][2:0] != 3'h7 |=> pump_current_ua == (7'h01 << $past(r_q[1][2:0])))
		else $error("pump current wrong");
endmodule : pcr_properties

bind pcr_top pcr_properties #(.OSC_COUNT_W(OSC_COUNT_W)) chk_u (
	.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.hold_input(hold_input), .sync_in(sync_in), .pll_locked(pll_locked),
	.pump_enable(pump_enable), .pump_current_ua(pump_current_ua),
	.vco_div_ratio(vco_div_ratio), .clk_div_ratio(clk_div_ratio),
	.phase_delay_elements(phase_delay_elements), .phase_delay_line(phase_delay_line),
	.phase_delay_bypass(phase_delay_bypass), .filter_internal(filter_internal),
	.detector_input(detector_input), .lock_ref_out(lock_ref_out), .irq(irq)
);
`default_nettype wire

// File: tb/tb_top.sv
// testbench: bus tasks and directed sequences for the pll control block
`default_nettype none
`define CHK(a, e) begin \
	compares++; \
	if ((a) !== (e)) begin \
		error_cnt++; \
		$display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); \
	end \
end
module tb_top
	import pcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock      = 1'b0;
	logic       reset_n    = 1'b0;
	logic [7:0] reg_addr   = 8'h00;
	logic [7:0] reg_wdata  = 8'h00;
	logic       reg_write  = 1'b0;
	logic       reg_read   = 1'b0;
	logic       hold_input = 1'b1;
	logic       pll_locked = 1'b0;
	logic       sync_run   = 1'b0;
	logic       sync_in;
	logic [7:0] reg_rdata;
	logic       pump_enable;
	logic [6:0] pump_current_ua;
	logic [4:0] vco_div_ratio;
	logic [3:0] clk_div_ratio;
	logic [6:0] phase_delay_elements;
	logic [5:0] phase_delay_line;
	logic       phase_delay_bypass;
	logic       filter_internal;
	logic       detector_input;
	logic       lock_ref_out;
	logic       irq;
	int         error_cnt = 0;
	int         compares  = 0;
	int         rises;
	int         i;

	always #20 clock = ~clock;

	pcr_top #(.OSC_COUNT_W(7)) dut_u (
		.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.hold_input(hold_input), .sync_in(sync_in), .pll_locked(pll_locked),
		.pump_enable(pump_enable), .pump_current_ua(pump_current_ua),
		.vco_div_ratio(vco_div_ratio), .clk_div_ratio(clk_div_ratio),
		.phase_delay_elements(phase_delay_elements), .phase_delay_line(phase_delay_line),
		.phase_delay_bypass(phase_delay_bypass), .filter_internal(filter_internal),
		.detector_input(detector_input), .lock_ref_out(lock_ref_out), .irq(irq)
	);

	pcr_sync_src sync_u (.clock(clock), .reset_n(reset_n), .run(sync_run), .sync_in(sync_in));

	task automatic close_out;
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	task automatic limit(input int k);
		if (k >= 300) begin
			error_cnt++;
			close_out();
		end
	endtask : limit

	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd

	// counts sync rises until the pump comes back on
	task automatic pump_wait;
		int   k;
		logic sp;
		sp = sync_in;
		rises = 0;
		for (k = 0; k < 300 && pump_enable !== 1'b1; k++) begin
			@(posedge clock);
			if (sync_in === 1'b1 && sp === 1'b0) rises++;
			sp = sync_in;
		end
		limit(k);
		`CHK(rises, 2)
	endtask : pump_wait

	task automatic refm(input logic [6:0] c, input int elo);
		int k;
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		wr(PCR_REG_OSC, {1'b1, c});
		tick(260);
		for (k = 0; k < 300 && detector_input !== 1'b1; k++) tick(1);
		limit(k);
		for (k = 0; k < 300 && detector_input === 1'b1; k++) begin
			tick(1);
			hi++;
		end
		limit(k);
		for (k = 0; k < 300 && detector_input !== 1'b1; k++) begin
			tick(1);
			lo++;
		end
		limit(k);
		`CHK(hi, 1)
		`CHK(lo, elo)
	endtask : refm

	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		tick(2);
		`CHK(pump_enable, 1'b1)
		`CHK(phase_delay_elements, PCR_ELEM_16)
		`CHK(lock_ref_out, 1'b0)
		rd(PCR_REG_CTRL, 8'h01);
		rd(8'h30, 8'h00);
		for (i = 0; i < 8; i++) begin
			wr(PCR_REG_PUMP, {2'b00, 2'(i), 1'b0, 3'(i)});
			wr(PCR_REG_CLKDIV, {2'(i), 6'h00});
			tick(2);
			`CHK(pump_current_ua, 7'h01 << ((i == 7) ? 6 : i))
			`CHK(vco_div_ratio, 5'h02 << (i % 4))
			`CHK(clk_div_ratio, 4'h1 << (i % 4))
		end
		wr(PCR_REG_PUMP, 8'h03);
		wr(PCR_REG_RES, {6'h00, PCR_RES_32});
		wr(PCR_REG_DELAY, 8'hbf);
		tick(2);
		`CHK(filter_internal, 1'b1)
		`CHK(phase_delay_elements, PCR_ELEM_16)
		`CHK(phase_delay_line, PCR_MAX_16)
		rd(PCR_REG_RES, 8'h01);
		wr(PCR_REG_SOFTRST, 8'hfa);
		tick(2);
		`CHK(phase_delay_elements, PCR_ELEM_32)
		`CHK(phase_delay_line, PCR_MAX_32)
		`CHK(phase_delay_bypass, 1'b0)
		wr(PCR_REG_RES, {6'h00, PCR_RES_RSVD});
		wr(PCR_REG_SOFTRST, 8'h0a);
		tick(2);
		`CHK(phase_delay_elements, PCR_ELEM_32)
		wr(PCR_REG_RES, {6'h00, PCR_RES_64});
		wr(PCR_REG_SOFTRST, 8'h0a);
		wr(PCR_REG_DELAY, 8'h00);
		tick(2);
		`CHK(phase_delay_elements, PCR_ELEM_64)
		`CHK(phase_delay_bypass, 1'b1)
		wr(PCR_REG_INT_STATUS, 8'hff);
		wr(PCR_REG_INT_MASK, 8'h02);
		wr(PCR_REG_CTRL, 8'h00);
		tick(2);
		`CHK(pump_enable, 1'b1)
		@(posedge clock);
		hold_input <= 1'b0;
		#1;
		`CHK(pump_enable, 1'b0)
		tick(3);
		`CHK(irq, 1'b1)
		wr(PCR_REG_INT_STATUS, 8'h02);
		@(posedge clock);
		hold_input <= 1'b1;
		tick(20);
		`CHK(irq, 1'b0)
		`CHK(pump_enable, 1'b0)
		@(posedge clock);
		sync_run <= 1'b1;
		pump_wait();
		wr(PCR_REG_CTRL, 8'h02);
		tick(1);
		`CHK(pump_enable, 1'b0)
		@(posedge clock);
		hold_input <= 1'b0;
		pump_wait();
		@(posedge clock);
		pll_locked <= 1'b1;
		for (i = 0; i < 3; i++) begin
			wr(PCR_REG_CTRL, {2'(i), 6'h01});
			tick(2);
			`CHK(lock_ref_out, (i == 1))
		end
		rd(PCR_REG_STATUS, 8'h02);
		wr(PCR_REG_CTRL, 8'hc5);
		wr(PCR_REG_INT_STATUS, 8'hff);
		@(posedge clock);
		pll_locked <= 1'b0;
		tick(40);
		`CHK(irq, 1'b0)
		rd(PCR_REG_INT_STATUS, 8'h01);
		rd(PCR_REG_STATUS, 8'h00);
		wr(PCR_REG_INT_MASK, 8'h03);
		tick(3);
		`CHK(irq, 1'b1)
		wr(PCR_REG_INT_STATUS, 8'h01);
		tick(3);
		`CHK(irq, 1'b0)
		wr(PCR_REG_CTRL, 8'hc1);
		refm(7'h01, 2);
		refm(7'h05, 6);
		refm(7'h00, 2);
		refm(7'h7f, 128);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
